// *** design/dot_clock_pkg.sv ***
// Notes on behaviour
// - A 4-bit select code is driven on four select lines, choosing one of sixteen dot clocks.
// - After power-on reset the select lines are zero and one strobe pulse is issued.
// - With the screen off, a strobe follows every write to the mode control or misc output register, whatever bits it changes.
// - Misc output bits 3:2 give code 0, 1, 2, or mode control bits 3:0 when they are 11.
// - The derived code is copied into the general output port low nibble before it is strobed, except for a vsync that rises while a strobe sequence runs.
// - With the screen on, one strobe is issued in every vertical sync interval.
// - General output port bits 7:4 are freely written, drive the upper lines and latch on each strobe.
package dot_clock_pkg;
	// ============================================================
	// Register addresses
	localparam logic [3:0]  SEQ_PORT        = 4'h5;
	localparam logic [7:0]  IDX_CLK_MODE    = 8'h01;
	localparam logic [7:0]  IDX_MODE_CODE   = 8'h42;
	localparam logic [7:0]  IDX_GEN_OUT     = 8'h5C;
	localparam logic [11:0] ADDR_MISC_OUT   = 12'h3C2;
	localparam logic [11:0] ADDR_SEQ_INDEX  = 12'h3C4;
	localparam logic [11:0] ADDR_SEQ_DATA   = 12'h3C5;
	localparam logic [11:0] ADDR_CRT_INDEX  = 12'h3D4;
	localparam logic [11:0] ADDR_CRT_DATA   = 12'h3D5;
	// ============================================================
	// Fields and reset values
	localparam int          SCREEN_OFF_BIT  = 5;
	localparam logic [7:0]  RESET_BYTE      = 8'h00;
	localparam logic [1:0]  MISC_SEL_CODE   = 2'h3;
	// ============================================================
	// Strobe timing
	localparam int          CLK_PERIOD_NS   = 50;
	localparam int          SETUP_NS        = 50;
	localparam int          PULSE_NS        = 100;
	localparam int          HOLD_NS         = 50;
	localparam logic [3:0]  SETUP_CYC = 4'((SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam logic [3:0]  PULSE_CYC = 4'((PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam logic [3:0]  HOLD_CYC  = 4'((HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

	typedef enum logic [1:0] {ST_IDLE, ST_SETUP, ST_PULSE, ST_HOLD} strobe_state_t;
endpackage

// *** design/strobe_if.sv ***
`timescale 1ns/10ps
interface strobe_if;
	logic       req;
	logic       busy;
	logic       active;
	modport ctrl (output req, input busy, input active);
	modport gen  (input req, output busy, output active);
endinterface

// *** design/strobe_gen.sv ***
`timescale 1ns/10ps
module strobe_gen
	import dot_clock_pkg::*;
(
	// Clock and reset
	input  wire logic I_CLK,
	input  wire logic I_RST,
	// Control
	strobe_if.gen     sif
);
	strobe_state_t state_q;
	logic [3:0]    cnt_q;
	logic          pend_q;

	// ============================================================
	// Sequencer: setup, fixed pulse, hold
	always_ff @(posedge I_CLK or posedge I_RST) begin
		if (I_RST) begin
			state_q <= ST_IDLE;
			cnt_q   <= 4'h0;
		end else begin
			case (state_q)
				ST_IDLE: begin
					if (sif.req || pend_q) begin
						state_q <= ST_SETUP;
						cnt_q   <= SETUP_CYC;
					end
				end
				ST_SETUP: begin
					if (cnt_q <= 4'h1) begin
						state_q <= ST_PULSE;
						cnt_q   <= PULSE_CYC;
					end else begin
						cnt_q <= cnt_q - 4'h1;
					end
				end
				ST_PULSE: begin
					if (cnt_q <= 4'h1) begin
						state_q <= ST_HOLD;
						cnt_q   <= HOLD_CYC;
					end else begin
						cnt_q <= cnt_q - 4'h1;
					end
				end
				ST_HOLD: begin
					if (cnt_q <= 4'h1) begin
						state_q <= ST_IDLE;
					end else begin
						cnt_q <= cnt_q - 4'h1;
					end
				end
				default: begin
					state_q <= ST_IDLE;
				end
			endcase
		end
	end

	// Request during a running pulse is kept for one more pulse
	always_ff @(posedge I_CLK or posedge I_RST) begin
		if (I_RST) begin
			pend_q <= 1'b0;
		end else if (state_q == ST_IDLE) begin
			pend_q <= 1'b0;
		end else if (sif.req) begin
			pend_q <= 1'b1;
		end
	end

	assign sif.busy   = (state_q != ST_IDLE);
	assign sif.active = (state_q == ST_PULSE);
endmodule

// *** design/dot_clock_select.sv ***
`timescale 1ns/10ps
module dot_clock_select
	import dot_clock_pkg::*;
(
	// Clock and reset
	input  wire logic        I_CLK,
	input  wire logic        I_RST,
	// Processor I/O port
	input  wire logic [11:0] I_IO_ADDR,
	input  wire logic        I_IO_WR,
	input  wire logic        I_IO_RD,
	input  wire logic [7:0]  I_IO_WDATA,
	output logic      [7:0]  O_IO_RDATA,
	// Display timing
	input  wire logic        I_VSYNC,
	// Pins
	output logic      [3:0]  O_CLOCK_SELECT_LINES,
	output logic      [3:0]  O_UPPER_OUTPUT_LINES,
	output logic             O_SELECT_LATCH_STROBE,
	output logic             O_SCREEN_BLANK
);
	logic [7:0] seq_index_q;
	logic [7:0] crt_index_q;
	logic [7:0] clk_mode_q;
	logic [7:0] mode_code_q;
	logic [7:0] gen_out_q;
	logic [7:0] misc_out_q;
	logic       vsync_q;
	logic       init_q;
	logic       upd_q;
	logic       lines_ld;
	logic [3:0] sel_code;
	logic       wr_misc;
	logic       wr_clk_mode;
	logic       wr_mode_code;
	logic       wr_gen_out;
	logic       wr_sel;
	logic       refresh_on;
	logic       go_q;
	logic       screen_off;
	logic       vs_rise;
	logic       req;
	logic [7:0] rdata_d;

	strobe_if sif ();

	strobe_gen u_strobe (
		.I_CLK (I_CLK),
		.I_RST (I_RST),
		.sif   (sif)
	);

	// ============================================================
	// Code derivation
	function automatic logic [3:0] derive_code(input logic [7:0] misc, input logic [7:0] mc);
		case (misc[3:2])
			2'h0:    derive_code = 4'h0;
			2'h1:    derive_code = 4'h1;
			2'h2:    derive_code = 4'h2;
			default: derive_code = mc[3:0];
		endcase
	endfunction

	// Hit on one register behind an index/data port pair
	function automatic logic idx_hit(input logic wr, input logic [11:0] addr,
		input logic [11:0] port, input logic [7:0] idx_q, input logic [7:0] idx);
		idx_hit = wr && (addr == port) && (idx_q == idx);
	endfunction

	assign sel_code     = derive_code(misc_out_q, mode_code_q);
	assign wr_misc      = I_IO_WR && (I_IO_ADDR == ADDR_MISC_OUT);
	assign wr_clk_mode  = idx_hit(I_IO_WR, I_IO_ADDR, ADDR_SEQ_DATA, seq_index_q, IDX_CLK_MODE);
	assign wr_mode_code = idx_hit(I_IO_WR, I_IO_ADDR, ADDR_CRT_DATA, crt_index_q, IDX_MODE_CODE);
	assign wr_gen_out   = idx_hit(I_IO_WR, I_IO_ADDR, ADDR_CRT_DATA, crt_index_q, IDX_GEN_OUT);
	assign screen_off   = clk_mode_q[SCREEN_OFF_BIT];
	// Any write to either code source counts, even with equal bits
	assign wr_sel       = wr_mode_code || wr_misc;
	assign vs_rise      = I_VSYNC && !vsync_q;
	// Screen-on refresh only while no strobe sequence runs
	assign refresh_on   = !screen_off && vs_rise && !sif.busy;

	// ============================================================
	// Registers
	// Index registers of both port pairs
	always_ff @(posedge I_CLK or posedge I_RST) begin
		if (I_RST) begin
			seq_index_q <= RESET_BYTE;
			crt_index_q <= RESET_BYTE;
		end else if (I_IO_WR) begin
			if (I_IO_ADDR == ADDR_SEQ_INDEX) begin
				seq_index_q <= I_IO_WDATA;
			end
			if (I_IO_ADDR == ADDR_CRT_INDEX) begin
				crt_index_q <= I_IO_WDATA;
			end
		end
	end

	// Miscellaneous output, picks the code source
	always_ff @(posedge I_CLK or posedge I_RST) begin
		if (I_RST) begin
			misc_out_q <= RESET_BYTE;
		end else if (wr_misc) begin
			misc_out_q <= I_IO_WDATA;
		end
	end

	// Clocking mode, holds the screen-off bit
	always_ff @(posedge I_CLK or posedge I_RST) begin
		if (I_RST) begin
			clk_mode_q <= RESET_BYTE;
		end else if (wr_clk_mode) begin
			clk_mode_q <= I_IO_WDATA;
		end
	end

	// Mode control code
	always_ff @(posedge I_CLK or posedge I_RST) begin
		if (I_RST) begin
			mode_code_q <= RESET_BYTE;
		end else if (wr_mode_code) begin
			mode_code_q <= I_IO_WDATA;
		end
	end

	// Copy code into port once the new values settle
	always_ff @(posedge I_CLK or posedge I_RST) begin
		if (I_RST) begin
			upd_q <= 1'b0;
		end else begin
			upd_q <= wr_sel && screen_off;
		end
	end

	// General output port: upper nibble by software, lower by hardware
	always_ff @(posedge I_CLK or posedge I_RST) begin
		if (I_RST) begin
			gen_out_q <= RESET_BYTE;
		end else begin
			if (wr_gen_out) begin
				gen_out_q[7:4] <= I_IO_WDATA[7:4];
			end
			if (upd_q || refresh_on) begin
				gen_out_q[3:0] <= sel_code;
			end
		end
	end

	// ============================================================
	// Strobe requests
	always_ff @(posedge I_CLK or posedge I_RST) begin
		if (I_RST) begin
			vsync_q <= 1'b0;
			init_q  <= 1'b1;
		end else begin
			vsync_q <= I_VSYNC;
			init_q  <= 1'b0;
		end
	end

	// Strobe asked on the same edge as the port takes the code,
	// so the idle line load still sees the new code
	always_ff @(posedge I_CLK or posedge I_RST) begin
		if (I_RST) begin
			go_q <= 1'b0;
		end else begin
			go_q <= upd_q
				|| (!screen_off && vs_rise);
		end
	end

	// Power-on pulse, post-write pulse when blanked, one per vsync when on
	assign req = init_q
		|| go_q;
	assign sif.req = req;

	// Pin lines follow the port only while strobe idle
	assign lines_ld = !sif.busy;

	always_ff @(posedge I_CLK or posedge I_RST) begin
		if (I_RST) begin
			O_CLOCK_SELECT_LINES <= 4'h0;
			O_UPPER_OUTPUT_LINES <= 4'h0;
		end else if (lines_ld) begin
			O_CLOCK_SELECT_LINES <= gen_out_q[3:0];
			O_UPPER_OUTPUT_LINES <= gen_out_q[7:4];
		end
	end

	always_ff @(posedge I_CLK or posedge I_RST) begin
		if (I_RST) begin
			O_SELECT_LATCH_STROBE <= 1'b0;
		end else begin
			O_SELECT_LATCH_STROBE <= sif.active;
		end
	end

	assign O_SCREEN_BLANK = screen_off;

	// ============================================================
	// Read back
	always_comb begin
		rdata_d = RESET_BYTE;
		if (I_IO_ADDR == ADDR_MISC_OUT) begin
			rdata_d = misc_out_q;
		end else if (I_IO_ADDR == ADDR_SEQ_INDEX) begin
			rdata_d = seq_index_q;
		end else if (I_IO_ADDR == ADDR_CRT_INDEX) begin
			rdata_d = crt_index_q;
		end else if (idx_hit(1'b1, I_IO_ADDR, ADDR_SEQ_DATA, seq_index_q, IDX_CLK_MODE)) begin
			rdata_d = clk_mode_q;
		end else if (idx_hit(1'b1, I_IO_ADDR, ADDR_CRT_DATA, crt_index_q, IDX_MODE_CODE)) begin
			rdata_d = mode_code_q;
		end else if (idx_hit(1'b1, I_IO_ADDR, ADDR_CRT_DATA, crt_index_q, IDX_GEN_OUT)) begin
			rdata_d = gen_out_q;
		end
	end

	always_ff @(posedge I_CLK or posedge I_RST) begin
		if (I_RST) begin
			O_IO_RDATA <= RESET_BYTE;
		end else if (I_IO_RD) begin
			O_IO_RDATA <= rdata_d;
		end
	end
endmodule

// *** verification/clock_chip_model.sv ***
`timescale 1ns/10ps
// ========
// Clock chip behind the latch buffer
module clock_chip_model (
	input  wire logic       i_strobe,
	input  wire logic [3:0] i_sel,
	input  wire logic [3:0] i_upper,
	output logic      [7:0] o_buf,
	output int              o_caps,
	output int              o_resyncs
);
	logic [3:0] prev;
	logic       armed;
	initial begin
		o_buf = 8'hFF;
		o_caps = 0;
		o_resyncs = 0;
		prev = 4'hF;
		armed = 1'b0;
	end
	always @(posedge i_strobe) armed = 1'b1;
	always @(negedge i_strobe) begin
		if (armed) begin
			o_buf = {i_upper, i_sel};
			o_caps = o_caps + 1;
			if (i_sel !== prev) o_resyncs = o_resyncs + 1;
			prev = i_sel;
		end
	end
endmodule

// *** verification/dot_clock_select_chk.sv ***
`timescale 1ns/10ps
// ========
// Strobe checker
module dot_clock_select_chk
	import dot_clock_pkg::*;
(
	input wire logic        I_CLK,
	input wire logic        I_RST,
	input wire logic [11:0] I_IO_ADDR,
	input wire logic        I_IO_WR,
	input wire logic        I_IO_RD,
	input wire logic        I_VSYNC,
	input wire logic [7:0]  O_IO_RDATA,
	input wire logic [3:0]  O_CLOCK_SELECT_LINES,
	input wire logic        O_SELECT_LATCH_STROBE,
	input wire logic        O_SCREEN_BLANK
);
	default clocking cb @(posedge I_CLK); endclocking
	default disable iff (I_RST);
	AST_WIDTH: assert property ($rose(O_SELECT_LATCH_STROBE) |->
		O_SELECT_LATCH_STROBE ##1 O_SELECT_LATCH_STROBE ##1 !O_SELECT_LATCH_STROBE)
		else $error("strobe width wrong");
	AST_HOLD: assert property ((O_SELECT_LATCH_STROBE || $past(O_SELECT_LATCH_STROBE)) |->
		$stable(O_CLOCK_SELECT_LINES)) else $error("select lines moved near strobe");
	AST_GAP: assert property ($fell(O_SELECT_LATCH_STROBE) |-> !O_SELECT_LATCH_STROBE [*2])
		else $error("strobes too close");
	AST_RESET_ZERO: assert property ($fell(I_RST) |-> (O_CLOCK_SELECT_LINES == 4'h0) [*6])
		else $error("lines not zero after reset");
	AST_RESET_PULSE: assert property ($fell(I_RST) |-> ##[1:6] $rose(O_SELECT_LATCH_STROBE))
		else $error("no strobe after reset");
	AST_BLANKED: assert property (O_SCREEN_BLANK && I_IO_WR && I_IO_ADDR == ADDR_MISC_OUT
		|-> ##[1:12] $rose(O_SELECT_LATCH_STROBE)) else $error("no strobe after write");
	AST_VSYNC: assert property (!O_SCREEN_BLANK && $rose(I_VSYNC)
		|-> ##[1:12] $rose(O_SELECT_LATCH_STROBE)) else $error("no strobe after vsync");
	AST_UNMAPPED: assert property (I_IO_RD && I_IO_ADDR == 12'h3C0 |=> O_IO_RDATA == 8'h00)
		else $error("unmapped read not zero");
endmodule
bind dot_clock_select dot_clock_select_chk u_chk (.I_CLK(I_CLK), .I_RST(I_RST),
	.I_IO_ADDR(I_IO_ADDR), .I_IO_WR(I_IO_WR), .I_IO_RD(I_IO_RD), .I_VSYNC(I_VSYNC),
	.O_IO_RDATA(O_IO_RDATA), .O_CLOCK_SELECT_LINES(O_CLOCK_SELECT_LINES),
	.O_SELECT_LATCH_STROBE(O_SELECT_LATCH_STROBE), .O_SCREEN_BLANK(O_SCREEN_BLANK));

// *** verification/dot_clock_select_test.sv ***
`timescale 1ns/10ps
module dot_clock_select_test;
	import dot_clock_pkg::*;
	logic        clk = 1'b0;
	logic        rst = 1'b1;
	logic [11:0] addr = 12'h000;
	logic        wr = 1'b0;
	logic        rd = 1'b0;
	logic [7:0]  wdata = 8'h00;
	logic        vsync = 1'b0;
	logic [7:0]  rdata;
	logic [3:0]  sel;
	logic [3:0]  upper;
	logic        strobe;
	logic        blank;
	logic [7:0]  chip_buf;
	int          caps;
	int          resyncs;
	int          n_errors = 0;
	int          comparisons = 0;
	initial forever #25 clk = ~clk;
	dot_clock_select DUT (.I_CLK(clk), .I_RST(rst), .I_IO_ADDR(addr), .I_IO_WR(wr),
		.I_IO_RD(rd), .I_IO_WDATA(wdata), .O_IO_RDATA(rdata), .I_VSYNC(vsync),
		.O_CLOCK_SELECT_LINES(sel), .O_UPPER_OUTPUT_LINES(upper),
		.O_SELECT_LATCH_STROBE(strobe), .O_SCREEN_BLANK(blank));
	clock_chip_model chip (.i_strobe(strobe), .i_sel(sel), .i_upper(upper),
		.o_buf(chip_buf), .o_caps(caps), .o_resyncs(resyncs));
	// ========
	// Shared tasks
	task automatic tally_and_finish();
		$display("errors %0d comparisons %0d", n_errors, comparisons);
		if (n_errors == 0 && comparisons > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		comparisons++;
		if (got !== exp) begin
			n_errors++;
			$display("Error %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wr_reg(input logic [11:0] a, input logic [7:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask
	task automatic wr_idx(input logic [11:0] a, input logic [7:0] i, input logic [7:0] d);
		wr_reg(a, i);
		wr_reg(a + 12'h001, d);
		@(posedge clk);
		#1;
	endtask
	task automatic rd_reg(input logic [11:0] a, output logic [7:0] d);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1 d = rdata;
	endtask
	task automatic wait_cap(input int n0);
		for (int i = 0; i < 40 && caps == n0; i++) @(posedge clk);
		if (caps == n0) begin
			n_errors++;
			$display("Error %0t: no strobe seen", $time);
			tally_and_finish();
		end else begin
			repeat (3) @(posedge clk);
		end
	endtask
	// ========
	// Scenarios
	task automatic t_reset();
		wait_cap(0);
		chk(chip_buf, 8'h00);
		chk(8'(caps), 8'h01);
	endtask
	task automatic t_blank();
		logic [7:0] d;
		logic [7:0] e;
		int         n;
		wr_idx(ADDR_SEQ_INDEX, IDX_CLK_MODE, 8'h20);
		chk({7'h00, blank}, 8'h01);
		n = caps;
		wr_idx(ADDR_CRT_INDEX, IDX_MODE_CODE, 8'hFD);
		wait_cap(n);
		for (int m = 0; m < 4; m++) begin
			e = (m == 3) ? 8'h0D : 8'(m);
			n = caps;
			wr_reg(ADDR_MISC_OUT, 8'(m << 2));
			wait_cap(n);
			chk({4'h0, chip_buf[3:0]}, e);
			wr_reg(ADDR_CRT_INDEX, IDX_GEN_OUT);
			rd_reg(ADDR_CRT_DATA, d);
			chk({4'h0, d[3:0]}, e);
		end
	endtask
	task automatic t_upper();
		int n;
		int r;
		n = caps;
		r = resyncs;
		wr_idx(ADDR_CRT_INDEX, IDX_GEN_OUT, 8'hA5);
		repeat (20) @(posedge clk);
		chk(8'(caps - n), 8'h00);
		chk({upper, sel}, 8'hAD);
		wr_reg(ADDR_MISC_OUT, 8'h0C);
		wait_cap(n);
		chk(chip_buf, 8'hAD);
		chk(8'(resyncs - r), 8'h00);
	endtask
	task automatic t_on();
		int n;
		wr_idx(ADDR_SEQ_INDEX, IDX_CLK_MODE, 8'h00);
		chk({7'h00, blank}, 8'h00);
		n = caps;
		repeat (3) begin
			@(posedge clk);
			vsync <= 1'b1;
			repeat (4) @(posedge clk);
			wr_reg(ADDR_MISC_OUT, 8'h04);
			vsync <= 1'b0;
			repeat (20) @(posedge clk);
		end
		chk(8'(caps - n), 8'h03);
		chk({4'h0, chip_buf[3:0]}, 8'h01);
	endtask
	task automatic t_unmapped();
		logic [7:0] d;
		rd_reg(12'h3C0, d);
		chk(d, 8'h00);
	endtask
	initial begin
		repeat (4) @(posedge clk);
		rst <= 1'b0;
		t_reset();
		t_blank();
		t_upper();
		t_on();
		t_unmapped();
		tally_and_finish();
	end
endmodule
